// file: core/dss_sequencer.sv
`timescale 1ns/1ps
`include "dss_params.svh"

//------------------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------------------
// Overview of operation
// - A fast stop ramps demand to zero at the fast-stop ramp time only.
// - Fast-stop timeout starts with the combined flag; expiry coasts and drops contactor.
// - During a fast stop the fast-stop current cap replaces every other clamp.
// - Current enabled only with aux enable, enable terminal, unquenched and healthy.
// - Run condition is host start AND aux start AND healthy.
// - In a normal stop, contactor stays energized for the hold delay after speed drops below threshold.
// - Combined fast-stop flag is host fast-stop OR hardwired terminal open.
// - A fast stop is latched and completes regardless of its inputs returning.
// - Normal stop ramps so full speed to zero takes at least the stop time (step is rounded down).
// - Normal stop exceeding its timeout disables the drive and drops the contactor.
// - Threshold below 0.25 percent keeps the drive enabled through the hold delay.
// - Hold delay timer starts when feedback falls below the zero-speed threshold in a normal stop.
// - Drive-started output shows the overall start condition, 1 for on.
// - A normal stop begins when the run condition (host start AND aux start AND healthy) goes false.
// - Threshold above 0.25 percent disables the drive during the hold delay.
// - Any enable loss cancels the hold delay and releases the contactor at once.
//------------------------------------------------------------------------------
module dss_sequencer
	import dss_pkg::*;
#(
	parameter int TICK_CYCLES  = `DSS_TICK_CYCLES,
	parameter int TENTH_TICKS  = `DSS_TENTH_TICKS
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        resetn,
	// Host logic requests, same clock domain.
	input  wire logic        start_request,
	input  wire logic        aux_start,
	input  wire logic        aux_enable,
	input  wire logic        fast_halt_request,
	input  wire logic        drive_healthy,
	input  wire logic        loop_unquenched,
	// Terminals, asynchronous: high means 24 V present.
	input  wire logic        hardwired_halt_terminal,
	input  wire logic        external_enable_terminal,
	// Speed values, magnitude in 0.01 % units.
	input  wire logic [15:0] speed_feedback,
	input  wire logic [15:0] total_setpoint,
	// Static configuration.
	input  wire dss_times_t  times,
	input  wire dss_levels_t levels,
	// Outputs to speed loop, current loop and contactor.
	output logic      [15:0] speed_demand,
	output logic      [15:0] current_limit,
	output logic             current_enable,
	output logic             contactor_on,
	output logic             combined_fast_halt_flag,
	output logic             drive_started
);

	if (TICK_CYCLES < 1 || TENTH_TICKS < 1) begin : g_bad_tick
		$error("dss_sequencer: bad tick settings");
	end

	//--------------------------------------------------------------------------
	// Terminal synchronisers
	//--------------------------------------------------------------------------
	logic [1:0] halt_sync;
	logic [1:0] enable_sync;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			halt_sync   <= 2'h3;
			enable_sync <= 2'h0;
		end else begin
			halt_sync   <= {halt_sync[0], hardwired_halt_terminal};
			enable_sync <= {enable_sync[0], external_enable_terminal};
		end
	end

	//--------------------------------------------------------------------------
	// Time base
	//--------------------------------------------------------------------------
	// Every timer steps on one 0.1 s pulse so the settings map directly.
	logic [31:0] tick_cnt;
	logic [31:0] tenth_cnt;
	logic        tick;
	logic        tenth;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
			tick_cnt <= '0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h1;
			tick     <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tenth_cnt <= '0;
			tenth     <= 1'b0;
		end else begin
			tenth <= 1'b0;
			if (tick) begin
				if (tenth_cnt == 32'(TENTH_TICKS - 1)) begin
					tenth_cnt <= '0;
					tenth     <= 1'b1;
				end else begin
					tenth_cnt <= tenth_cnt + 32'h1;
				end
			end
		end
	end

	//--------------------------------------------------------------------------
	// Start and halt conditions
	//--------------------------------------------------------------------------
	logic run_cond;
	logic halt_now;
	logic fast_latched;
	logic below_zero;

	assign run_cond   = start_request & aux_start & drive_healthy;
	assign halt_now   = fast_halt_request | ~halt_sync[1];
	assign below_zero = speed_feedback < levels.stop_zero_speed;

	//--------------------------------------------------------------------------
	// Sequencer
	//--------------------------------------------------------------------------
	dss_state_t  state;
	dss_state_t  next_state;
	logic [15:0] stop_timer;
	logic [15:0] hold_timer;
	logic        timed_out;
	logic        hold_done;
	logic        disabled_now;

	assign timed_out = (state == DSS_FAST)
		? (stop_timer >= times.fast_halt_timeout_setting)
		: (stop_timer >= times.stop_timeout);
	assign hold_done = hold_timer >= times.hold_delay;
	// Drive is off in hold when the threshold is high, or on any enable loss.
	assign disabled_now = ~(aux_enable & enable_sync[1] & loop_unquenched & drive_healthy);

	always_comb begin
		next_state = state;
		case (state)
			DSS_IDLE: begin
				if (run_cond && !halt_now) begin
					next_state = DSS_RUN;
				end
			end
			DSS_RUN: begin
				if (halt_now) begin
					next_state = DSS_FAST;
				end else if (!run_cond) begin
					// RUN is only entered with the condition true, so a low level is its fall.
					next_state = DSS_STOP;
				end
			end
			DSS_STOP: begin
				if (halt_now) begin
					next_state = DSS_FAST;
				end else if (timed_out || disabled_now) begin
					next_state = DSS_IDLE;
				end else if (below_zero) begin
					next_state = DSS_HOLD;
				end else if (run_cond) begin
					next_state = DSS_RUN;
				end
			end
			DSS_FAST: begin
				// Latched: only completion, timeout or disable ends it.
				if (timed_out || disabled_now) begin
					next_state = DSS_IDLE;
				end else if (below_zero && speed_demand == '0) begin
					next_state = DSS_IDLE;
				end
			end
			DSS_HOLD: begin
				if (halt_now) begin
					next_state = DSS_FAST;
				end else if (disabled_now || hold_done) begin
					next_state = DSS_IDLE;
				end else if (run_cond) begin
					next_state = DSS_RUN;
				end
			end
			default: begin
				next_state = DSS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state <= DSS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign fast_latched = (state == DSS_FAST);

	// Stop timeout starts on entry to a stop, including the halt flag rising.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stop_timer <= '0;
		end else if (next_state != state) begin
			stop_timer <= '0;
		end else if (tenth && stop_timer != 16'hffff) begin
			stop_timer <= stop_timer + 16'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			hold_timer <= '0;
		end else if (state != DSS_HOLD) begin
			hold_timer <= '0;
		end else if (tenth && hold_timer != 16'hffff) begin
			hold_timer <= hold_timer + 16'h1;
		end
	end

	//--------------------------------------------------------------------------
	// Speed demand ramp
	//--------------------------------------------------------------------------
	logic [15:0] normal_step;
	logic [15:0] fast_step;
	logic [15:0] ramp_step;

	dss_ramp_step #(.WIDTH(16)) u_normal_step (
		.clk       (clk),
		.resetn    (resetn),
		.ramp_time (times.stop_ramp_time),
		.step      (normal_step)
	);

	dss_ramp_step #(.WIDTH(16)) u_fast_step (
		.clk       (clk),
		.resetn    (resetn),
		.ramp_time (times.fast_halt_ramp_setting),
		.step      (fast_step)
	);

	// The ordinary deceleration time is never used while stopping.
	assign ramp_step = fast_latched ? fast_step : normal_step;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			speed_demand <= '0;
		end else begin
			case (state)
				DSS_RUN: begin
					speed_demand <= total_setpoint;
				end
				DSS_STOP, DSS_FAST: begin
					if (tenth) begin
						speed_demand <= (speed_demand > ramp_step)
							? speed_demand - ramp_step : 16'h0;
					end
				end
				default: begin
					speed_demand <= '0;
				end
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// Outputs to current loop and contactor
	//--------------------------------------------------------------------------
	logic next_enable;
	logic next_contactor;

	always_comb begin
		next_contactor = (next_state != DSS_IDLE);
		next_enable    = next_contactor & ~disabled_now;
		if (next_state == DSS_HOLD && levels.stop_zero_speed > `DSS_LOW_ZERO_SPEED) begin
			next_enable = 1'b0;
		end
		// Below the low threshold the drive stays on through the hold.
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			current_enable <= 1'b0;
			contactor_on   <= 1'b0;
		end else begin
			current_enable <= next_enable;
			contactor_on   <= next_contactor;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			current_limit           <= `DSS_DEF_FAST_ILIM;
			combined_fast_halt_flag <= 1'b0;
			drive_started           <= 1'b0;
		end else begin
			current_limit <= (next_state == DSS_FAST)
				? levels.fast_halt_current_cap : levels.normal_current_cap;
			combined_fast_halt_flag <= halt_now;
			drive_started           <= run_cond;
		end
	end

endmodule

// file: core/dss_params.svh
`ifndef DSS_PARAMS_SVH
`define DSS_PARAMS_SVH

// Clock and timer tick.
`define DSS_CLK_HZ           40000000
`define DSS_TICK_US          100
`define DSS_TICK_CYCLES      ((`DSS_CLK_HZ / 1000000) * `DSS_TICK_US)

// Time settings are in units of 0.1 s.
`define DSS_TENTH_TICKS      1000

// Percent values are in units of 0.01 %.
`define DSS_FULL_SPEED       16'd10000
`define DSS_LOW_ZERO_SPEED   16'd25

// Defaults, in the units above.
`define DSS_DEF_FAST_RAMP    16'd1
`define DSS_DEF_FAST_TMO     16'd600
`define DSS_DEF_STOP_RAMP    16'd100
`define DSS_DEF_STOP_TMO     16'd600
`define DSS_DEF_HOLD         16'd10
`define DSS_DEF_ZERO_SPEED   16'd200
`define DSS_DEF_FAST_ILIM    16'd10000

`endif

// file: core/dss_pkg.sv
package dss_pkg;

	typedef enum logic [4:0] {
		DSS_IDLE = 5'b00001,
		DSS_RUN  = 5'b00010,
		DSS_STOP = 5'b00100,
		DSS_FAST = 5'b01000,
		DSS_HOLD = 5'b10000
	} dss_state_t;

	// Static time settings, all in 0.1 s units.
	typedef struct packed {
		logic [15:0] fast_halt_ramp_setting;
		logic [15:0] fast_halt_timeout_setting;
		logic [15:0] stop_ramp_time;
		logic [15:0] stop_timeout;
		logic [15:0] hold_delay;
	} dss_times_t;

	// Static levels, all in 0.01 % units.
	typedef struct packed {
		logic [15:0] stop_zero_speed;
		logic [15:0] fast_halt_current_cap;
		logic [15:0] normal_current_cap;
	} dss_levels_t;

endpackage

// file: core/dss_ramp_step.sv
`timescale 1ns/1ps
`include "dss_params.svh"

// Works out how far the demand moves per 0.1 s so that full speed
// reaches zero in the given time; the result is registered.
module dss_ramp_step
	import dss_pkg::*;
#(
	parameter int WIDTH = 16
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             resetn,
	// Ramp time in 0.1 s units.
	input  wire logic [WIDTH-1:0] ramp_time,
	// Demand change per 0.1 s, in 0.01 % units.
	output logic      [WIDTH-1:0] step
);

	if (WIDTH < 16) begin : g_bad_width
		$error("dss_ramp_step: WIDTH too small");
	end

	logic [WIDTH-1:0] divisor;
	logic [WIDTH-1:0] quotient;

	// A zero time would divide by zero, so it is treated as 0.1 s.
	always_comb begin
		divisor = (ramp_time == '0) ? WIDTH'(1) : ramp_time;
		quotient = WIDTH'(`DSS_FULL_SPEED / divisor);
		if (quotient == '0) begin
			quotient = WIDTH'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			step <= '0;
		end else begin
			step <= quotient;
		end
	end

endmodule

// file: tb/dss_sequencer_properties.sv
`timescale 1ns/1ps
//----------------------------------------
// Port relations of the stop sequencer
//----------------------------------------
module dss_sequencer_properties
	import dss_pkg::*;
#(
	parameter int TICK_CYCLES = 1,
	parameter int TENTH_TICKS = 1
) (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        resetn,
	// Requests, terminals and settings.
	input wire logic        start_request,
	input wire logic        aux_start,
	input wire logic        aux_enable,
	input wire logic        fast_halt_request,
	input wire logic        drive_healthy,
	input wire logic        loop_unquenched,
	input wire logic        hardwired_halt_terminal,
	input wire logic        external_enable_terminal,
	input wire dss_times_t  times,
	input wire dss_levels_t levels,
	// Outputs.
	input wire logic [15:0] speed_demand,
	input wire logic [15:0] current_limit,
	input wire logic        current_enable,
	input wire logic        contactor_on,
	input wire logic        combined_fast_halt_flag,
	input wire logic        drive_started
);
	logic [3:0]  term_hist;
	int unsigned coast_cnt;
	// The history spans the terminal synchroniser, so no check races it.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			term_hist <= 4'hf;
		end else begin
			term_hist <= {term_hist[2:0], hardwired_halt_terminal};
		end
	end
	// A stuck stop keeps this climbing until a timeout ends it.
	always_ff @(posedge clk) begin
		if (!resetn || !contactor_on || drive_started) begin
			coast_cnt <= 0;
		end else begin
			coast_cnt <= coast_cnt + 1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_flag_set: assert property (
		$past(fast_halt_request) || term_hist == 4'h0 |-> combined_fast_halt_flag)
		else $error("halt flag missing");
	a_flag_clear: assert property (
		!$past(fast_halt_request) && term_hist == 4'hf |-> !combined_fast_halt_flag)
		else $error("halt flag without cause");
	a_started_and: assert property (
		$past(resetn) |-> drive_started == $past(start_request && aux_start && drive_healthy))
		else $error("drive started wrong");
	a_fast_cap: assert property (
		contactor_on && combined_fast_halt_flag
		|-> ##[0:2] current_limit == levels.fast_halt_current_cap)
		else $error("fast cap not applied");
	a_fast_latch: assert property (
		$fell(combined_fast_halt_flag) && current_enable && speed_demand != 16'h0
		&& current_limit == levels.fast_halt_current_cap
		|=> current_limit == levels.fast_halt_current_cap)
		else $error("fast stop not latched");
	a_demand_falls: assert property (
		!drive_started |=> speed_demand <= $past(speed_demand))
		else $error("demand rose while stopped");
	a_gate_enable: assert property (
		(!aux_enable || !loop_unquenched || !drive_healthy) [*3] |-> !current_enable)
		else $error("current enabled while gated");
	a_term_enable: assert property (
		!external_enable_terminal [*5] |-> !current_enable)
		else $error("current enabled without terminal");
	a_coast_bound: assert property (
		coast_cnt <= (times.stop_timeout + times.fast_halt_timeout_setting + times.hold_delay
			+ 3) * TICK_CYCLES * TENTH_TICKS)
		else $error("stop outlived its timeout");
endmodule

// file: tb/dss_motor.sv
`timescale 1ns/1ps
//----------------------------------------
// Motor and power stage
//----------------------------------------
// A stalled load holds its speed, so a stop cannot reach zero speed before its timeout.
module dss_motor (
	input  wire logic        clk,
	input  wire logic        stall,
	input  wire logic [15:0] speed_demand,
	output logic      [15:0] speed_feedback = 16'h0
);
	always @(posedge clk) begin
		if (!stall) begin
			speed_feedback <= speed_demand;
		end
	end
endmodule

// file: tb/dss_sequencer_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin num_errors++; $display("mismatch %s expected %0h seen %0h", n, e, s); end end
//----------------------------------------
// Bench
//----------------------------------------
module dss_sequencer_test
	import dss_pkg::*;
;
	localparam int T = 2;
	logic        clk = 1'b0, resetn = 1'b0, start_request = 1'b0, aux_start = 1'b1;
	logic        aux_enable = 1'b1, fast_halt_request = 1'b0, drive_healthy = 1'b1;
	logic        loop_unquenched = 1'b1, halt_term = 1'b1, en_term = 1'b1, stall = 1'b0;
	logic [15:0] sp = 16'h0, fb, demand, ilim;
	logic        i_en, contactor_on, flag, started;
	dss_times_t  times = {16'h28, 16'h258, 16'h14, 16'h258, 16'ha};
	dss_levels_t levels = {16'hc8, 16'h1388, 16'h2710};
	int          num_errors = 0, n_checks = 0, k, e;
	bit          exp_run, exp_halt, chk_on;
	logic [1:0]  term_q = 2'h3;
	dss_sequencer #(.TICK_CYCLES(1), .TENTH_TICKS(T)) dut_u (.clk(clk), .resetn(resetn),
		.start_request(start_request), .aux_start(aux_start), .aux_enable(aux_enable),
		.fast_halt_request(fast_halt_request), .drive_healthy(drive_healthy),
		.loop_unquenched(loop_unquenched), .hardwired_halt_terminal(halt_term),
		.external_enable_terminal(en_term), .speed_feedback(fb), .total_setpoint(sp),
		.times(times), .levels(levels), .speed_demand(demand), .current_limit(ilim),
		.current_enable(i_en), .contactor_on(contactor_on), .combined_fast_halt_flag(flag),
		.drive_started(started));
	dss_motor mot_u (.clk(clk), .stall(stall), .speed_demand(demand), .speed_feedback(fb));
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Reference for the two flags, fed with the inputs as the design samples them.
	always @(posedge clk) begin
		exp_run  = start_request && aux_start && drive_healthy;
		exp_halt = fast_halt_request || !term_q[1];
		chk_on   = resetn;
		term_q   = resetn ? {term_q[0], halt_term} : 2'h3;
		#1;
		if (chk_on) begin
			`CHK("started_model", exp_run, started)
			`CHK("flag_model", exp_halt, flag)
		end
	end
	task automatic results;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_for(input int w, input int lim);
		k = 0;
		#1;
		while (k < lim && (w == 0 ? demand != 0 : w == 1 ? contactor_on : fb >= sp)) begin
			cyc(1);
			k++;
		end
		if (k >= lim) begin
			$display("mismatch wait %0d expected done seen timeout", w);
			num_errors++;
			results();
		end
	endtask
	task automatic go;
		@(posedge clk);
		sp <= 16'(5000 + $urandom % 5001);
		start_request <= 1'b1;
		cyc(6);
		`CHK("demand", sp, demand)
	endtask
	task automatic norm_stop(input logic [15:0] zs, input bit cut);
		@(posedge clk);
		levels.stop_zero_speed <= zs;
		go();
		@(posedge clk);
		start_request <= 1'b0;
		e = (sp + 499) / 500 * T;
		wait_for(0, 400);
		`CHK("ramp", 1'b1, k + T + 2 >= e && k <= e + T + 2)
		@(posedge clk);
		sp <= zs;
		wait_for(2, 8);
		cyc(3);
		`CHK("hold_en", zs <= 16'd25, i_en)
		`CHK("hold_on", 1'b1, contactor_on)
		if (cut) begin
			@(posedge clk);
			aux_enable <= 1'b0;
			cyc(3);
			`CHK("cut", 1'b0, contactor_on)
			@(posedge clk);
			aux_enable <= 1'b1;
		end else begin
			wait_for(1, 60);
			`CHK("hold", 1'b1, k >= 6 * T && k <= 10 * T)
		end
	endtask
	task automatic fast(input bit term);
		go();
		@(posedge clk);
		fast_halt_request <= !term;
		halt_term <= !term;
		cyc(4);
		`CHK("flag", 1'b1, flag)
		`CHK("fast_cap", levels.fast_halt_current_cap, ilim)
		@(posedge clk);
		fast_halt_request <= 1'b0;
		halt_term <= 1'b1;
		e = (sp + 249) / 250 * T;
		wait_for(0, 400);
		`CHK("fast_ramp", 1'b1, k + T + 8 >= e && k + 5 <= e + T + 3)
		@(posedge clk);
		start_request <= 1'b0;
		wait_for(1, 200);
	endtask
	initial begin
		void'($urandom(32'h40a957a9));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		cyc(2);
		`CHK("rst_limit", 16'h2710, ilim)
		`CHK("rst_on", 1'b0, contactor_on)
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			{drive_healthy, aux_start, start_request} <= 3'(i);
			cyc(2);
			`CHK("started", i == 7, started)
		end
		@(posedge clk);
		start_request <= 1'b0;
		wait_for(1, 100);
		norm_stop(16'hc8, 1'b0);
		norm_stop(16'h14, 1'b0);
		norm_stop(16'h14, 1'b1);
		fast(1'b0);
		fast(1'b1);
		go();
		@(posedge clk);
		stall <= 1'b1;
		times.stop_timeout <= 16'h5;
		times.fast_halt_timeout_setting <= 16'h3;
		@(posedge clk);
		start_request <= 1'b0;
		wait_for(1, 40);
		`CHK("stop_tmo", 1'b1, k >= 4 * T && k <= 5 * T + 3)
		@(posedge clk);
		stall <= 1'b0;
		go();
		@(posedge clk);
		stall <= 1'b1;
		fast_halt_request <= 1'b1;
		wait_for(1, 40);
		`CHK("fast_tmo", 1'b1, k >= 2 * T && k <= 3 * T + 4)
		@(posedge clk);
		{stall, fast_halt_request, start_request} <= 3'h0;
		go();
		for (int g = 0; g < 4; g++) begin
			@(posedge clk);
			{aux_enable, loop_unquenched, en_term, drive_healthy} <= ~(4'h8 >> g);
			cyc(5);
			`CHK("gate", 1'b0, i_en)
			@(posedge clk);
			{aux_enable, loop_unquenched, en_term, drive_healthy} <= 4'hf;
		end
		start_request <= 1'b0;
		wait_for(1, 200);
		results();
	end
endmodule
bind dss_sequencer dss_sequencer_properties #(
	.TICK_CYCLES(TICK_CYCLES),
	.TENTH_TICKS(TENTH_TICKS)
) chk_u (.clk(clk), .resetn(resetn), .start_request(start_request),
	.aux_start(aux_start), .aux_enable(aux_enable), .fast_halt_request(fast_halt_request),
	.drive_healthy(drive_healthy), .loop_unquenched(loop_unquenched),
	.hardwired_halt_terminal(hardwired_halt_terminal),
	.external_enable_terminal(external_enable_terminal), .times(times), .levels(levels),
	.speed_demand(speed_demand), .current_limit(current_limit),
	.current_enable(current_enable), .contactor_on(contactor_on),
	.combined_fast_halt_flag(combined_fast_halt_flag), .drive_started(drive_started));
